// [rtl/mrl_fifo.v]
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and a synchronous active-high reset.
 */
module mrl_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire clk_in,
    input wire reset_in,
    input wire [WIDTH-1:0] wr_data_in,
    input wire wr_valid_in,
    output wire wr_ready_out,
    output wire [WIDTH-1:0] rd_data_out,
    output wire rd_valid_out,
    input wire rd_ready_in
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wp_q;
    reg [AW-1:0] rp_q;
    reg [AW:0] cnt_q;
    wire do_wr;
    wire do_rd;

    assign wr_ready_out = (cnt_q != DEPTH[AW:0]);
    assign rd_valid_out = (cnt_q != {(AW+1){1'b0}});
    assign rd_data_out = mem[rp_q];
    assign do_wr = wr_valid_in & wr_ready_out;
    assign do_rd = rd_valid_out & rd_ready_in;

    always @(posedge clk_in) begin
        if (reset_in) begin
            wp_q <= {AW{1'b0}};
            rp_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                mem[wp_q] <= wr_data_in;
                wp_q <= (wp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_q + 1'b1;
            end
            if (do_rd) begin
                rp_q <= (rp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_q + 1'b1;
            end
            if (do_wr && !do_rd) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (do_rd && !do_wr) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

// [rtl/mrl_loader.v]
/*
 * Two-wire slave port that loads and reads back the program RAM of the
 * embedded processor, and holds that processor in reset for loads and for reads armed by the read subaddress.
 * Assumes scl/sda are sampled synchronously to clk_in and change slowly
 * (several clk_in cycles per bus phase); the sda pin is open drain.
 */
`include "mrl_defs.vh"
module mrl_loader #(
    parameter RAM_AW = `MRL_RAM_AW
) (
    input wire clk_in,
    input wire reset_in,
    input wire scl_in,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe_out,
    input wire address_select_strap_in,
    output reg cpu_reset_out,
    output reg [RAM_AW-1:0] ram_addr_out,
    output reg ram_busy_out
);
    localparam ST_IDLE = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_SUB = 3'h2;
    localparam ST_WDATA = 3'h3;
    localparam ST_RDATA = 3'h4;
    localparam ST_RACK = 3'h5;
    localparam ST_SKIP = 3'h6;
    localparam MODE_NONE = 2'h0;
    localparam MODE_WR = 2'h1;
    localparam MODE_RD = 2'h2;
    localparam MODE_REL = 2'h3;

    reg [7:0] ram [0:(1<<RAM_AW)-1];
    reg scl_q;
    reg sda_q;
    reg [2:0] state_q;
    reg [3:0] bit_q;
    reg [7:0] shift_q;
    reg [1:0] mode_q;
    reg read_armed_q;
    reg ack_q;
    reg ack_on_q;
    reg strap_q;
    reg [RAM_AW-1:0] wptr_q;
    reg [RAM_AW-1:0] rptr_q;
    reg [7:0] tx_q;

    wire scl_rise = scl_in & ~scl_q;
    wire scl_fall = ~scl_in & scl_q;
    wire start_ev = scl_in & scl_q & sda_q & ~sda_in;
    wire stop_ev = scl_in & scl_q & ~sda_q & sda_in;
    wire [7:0] byte_in = {shift_q[6:0], sda_in};

    wire [7:0] fifo_out;
    wire fifo_valid;
    wire fifo_ready;
    wire fifo_push = (state_q == ST_WDATA) & scl_rise & (bit_q == 4'h7) & (mode_q == MODE_WR);

    // The FIFO decouples byte capture from the RAM write port
    mrl_fifo #(
        .WIDTH(8),
        .DEPTH(`MRL_FIFO_DEPTH),
        .AW(2)
    ) u_fifo (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .wr_data_in(byte_in),
        .wr_valid_in(fifo_push),
        .wr_ready_out(fifo_ready),
        .rd_data_out(fifo_out),
        .rd_valid_out(fifo_valid),
        .rd_ready_in(1'b1)
    );

    function addr_match;
        input [7:0] b;
        input s;
        begin
            addr_match = (b[7:2] == `MRL_ADDR_HI) && (b[1] == s);
        end
    endfunction

    always @(posedge clk_in) begin
        if (reset_in) begin
            wptr_q <= {RAM_AW{1'b0}};
        end else if (fifo_valid) begin
            ram[wptr_q] <= fifo_out;
            wptr_q <= wptr_q + 1'b1;
        end else if (state_q == ST_SUB && scl_rise && bit_q == 4'h7 &&
                     byte_in == `MRL_SUB_WRITE) begin
            wptr_q <= {RAM_AW{1'b0}};
        end
    end

    always @(posedge clk_in) begin
        if (reset_in) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            state_q <= ST_IDLE;
            bit_q <= 4'h0;
            shift_q <= 8'h00;
            mode_q <= MODE_NONE;
            read_armed_q <= 1'b0;
            ack_q <= 1'b0;
            ack_on_q <= 1'b0;
            strap_q <= 1'b0;
            rptr_q <= {RAM_AW{1'b0}};
            tx_q <= 8'h00;
            sda_out <= 1'b0;
            sda_oe_out <= 1'b0;
            cpu_reset_out <= 1'b0;
            ram_addr_out <= {RAM_AW{1'b0}};
            ram_busy_out <= 1'b0;
        end else begin
            scl_q <= scl_in;
            sda_q <= sda_in;
            // Strap is sampled each cycle after release, never under reset
            strap_q <= address_select_strap_in;
            ram_addr_out <= wptr_q;
            ram_busy_out <= fifo_valid | (mode_q == MODE_WR) | (mode_q == MODE_RD);
            if (start_ev) begin
                state_q <= ST_ADDR;
                bit_q <= 4'h0;
                ack_q <= 1'b0;
                ack_on_q <= 1'b0;
                sda_oe_out <= 1'b0;
                mode_q <= MODE_NONE;
            end else if (stop_ev) begin
                state_q <= ST_IDLE;
                ack_q <= 1'b0;
                ack_on_q <= 1'b0;
                sda_oe_out <= 1'b0;
                mode_q <= MODE_NONE;
            end else if (scl_fall) begin
                if (ack_q && !ack_on_q) begin
                    // Ack goes low only with scl low, else it would look like a start
                    ack_on_q <= 1'b1;
                    sda_oe_out <= 1'b1;
                end else if (ack_q) begin
                    // End of our ack slot: release the line, or drive the first data bit in ST_RDATA
                    ack_q <= 1'b0;
                    ack_on_q <= 1'b0;
                    sda_oe_out <= (state_q == ST_RDATA) & ~tx_q[7];
                    bit_q <= 4'h0;
                end else if (state_q == ST_RDATA && bit_q != 4'h8) begin
                    sda_oe_out <= ~tx_q[7];
                end else if (state_q == ST_RACK) begin
                    sda_oe_out <= 1'b0;
                end
            end else if (scl_rise && !ack_q) begin
                case (state_q)
                    ST_ADDR, ST_SUB, ST_WDATA: begin
                        shift_q <= byte_in;
                        bit_q <= bit_q + 1'b1;
                        if (bit_q == 4'h7) begin
                            ack_q <= 1'b1;
                            state_q <= ST_WDATA;
                            if (state_q == ST_ADDR) begin
                                if (!addr_match(byte_in, strap_q)) begin
                                    ack_q <= 1'b0;
                                    sda_oe_out <= 1'b0;
                                    state_q <= ST_SKIP;
                                end else if (byte_in[`MRL_RW_BIT]) begin
                                    state_q <= ST_RDATA;
                                    tx_q <= ram[rptr_q];
                                    rptr_q <= rptr_q + 1'b1;
                                    mode_q <= read_armed_q ? MODE_RD : MODE_NONE;
                                end else begin
                                    state_q <= ST_SUB;
                                end
                            end else if (state_q == ST_SUB) begin
                                if (byte_in == `MRL_SUB_WRITE) begin
                                    mode_q <= MODE_WR;
                                    read_armed_q <= 1'b0;
                                    cpu_reset_out <= 1'b1;
                                end else if (byte_in == `MRL_SUB_READ) begin
                                    mode_q <= MODE_NONE;
                                    read_armed_q <= 1'b1;
                                    rptr_q <= {RAM_AW{1'b0}};
                                    cpu_reset_out <= 1'b1;
                                end else if (byte_in == `MRL_SUB_RELEASE) begin
                                    mode_q <= MODE_REL;
                                end else begin
                                    mode_q <= MODE_NONE;
                                end
                            end else if (mode_q == MODE_WR) begin
                                // Full FIFO: refuse the byte rather than lose it
                                if (!fifo_ready) begin
                                    ack_q <= 1'b0;
                                    sda_oe_out <= 1'b0;
                                    state_q <= ST_SKIP;
                                end
                            end else if (mode_q == MODE_REL) begin
                                cpu_reset_out <= 1'b0;
                                read_armed_q <= 1'b0;
                                mode_q <= MODE_NONE;
                            end
                        end
                    end
                    ST_RDATA: begin
                        if (bit_q == 4'h7) begin
                            state_q <= ST_RACK;
                        end else begin
                            tx_q <= {tx_q[6:0], 1'b0};
                            bit_q <= bit_q + 1'b1;
                        end
                    end
                    ST_RACK: begin
                        // Master ack continues, no-ack ends the stream
                        if (!sda_in) begin
                            state_q <= ST_RDATA;
                            bit_q <= 4'h8;
                            tx_q <= ram[rptr_q];
                            rptr_q <= rptr_q + 1'b1;
                        end else begin
                            state_q <= ST_SKIP;
                        end
                    end
                    ST_SKIP: begin
                        bit_q <= bit_q;
                    end
                    default: begin
                        state_q <= ST_IDLE;
                    end
                endcase
            end else if (state_q == ST_RDATA && bit_q == 4'h8 && !scl_in && !ack_q) begin
                bit_q <= 4'h0;
                sda_oe_out <= ~tx_q[7];
            end
        end
    end
endmodule

// [shared/mrl_defs.vh]
/*
 * Constants for the microcode RAM loader: slave address, subaddresses,
 * read/write bit position, FIFO depth and RAM address width.
 * Assumes inclusion by bare name from design files.
 */
`ifndef MRL_DEFS_VH
`define MRL_DEFS_VH
`define MRL_ADDR_HI 6'h2E
`define MRL_SUB_WRITE 8'h7E
`define MRL_SUB_RELEASE 8'h7F
`define MRL_SUB_READ 8'h8E
`define MRL_RW_BIT 0
`define MRL_FIFO_DEPTH 4
`define MRL_RAM_AW 10
`endif

// [verif/mrl_host_model.sv]
/* Two-wire bus master model for the loader port.
   Assumes the bench resolves the open-drain data wire with a pull-up. */
module mrl_host_model (
    input wire clk_in,
    input wire sda_line_in,
    output logic scl_out,
    output logic sda_drv_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        scl_out = 1'b1;
        sda_drv_out = 1'b1;
    end
    // Five cycles a phase keeps every phase above the four-cycle minimum
    task automatic wait_ph;
        repeat (5) @(posedge clk_in);
    endtask
    task automatic bus_start;
        sda_drv_out <= 1'b0;
        wait_ph;
        scl_out <= 1'b0;
    endtask
    task automatic bus_stop;
        wait_ph;
        sda_drv_out <= 1'b0;
        wait_ph;
        scl_out <= 1'b1;
        wait_ph;
        sda_drv_out <= 1'b1;
        wait_ph;
    endtask
    // Data moves only while the clock is low
    task automatic xfer_bit(input logic b, output logic r);
        wait_ph;
        sda_drv_out <= b;
        wait_ph;
        scl_out <= 1'b1;
        wait_ph;
        r = sda_line_in;
        scl_out <= 1'b0;
    endtask
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) xfer_bit(b[i], r);
        xfer_bit(1'b1, r);
        ack = ~r;
    endtask
    task automatic get_byte(input logic ack, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(1'b1, r);
            b[i] = r;
        end
        xfer_bit(~ack, r);
    endtask
endmodule

// [verif/mrl_loader_checker.sv]
/* Port checker for mrl_loader.
   Assumes a bind to mrl_loader, synchronous active-high reset. */
module mrl_loader_checker #(
    parameter RAM_AW = 10
) (
    input wire clk_in,
    input wire reset_in,
    input wire scl_in,
    input wire sda_out,
    input wire sda_oe_out,
    input wire cpu_reset_out,
    input wire [RAM_AW-1:0] ram_addr_out,
    input wire ram_busy_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);
    sequence oe_gone;
        ##[1:100] !sda_oe_out;
    endsequence
    sequence held_low;
        !cpu_reset_out [*8];
    endsequence
    sda_open_drain_a: assert property (sda_out == 1'b0) else $error("data pin driven high");
    oe_release_a: assert property (sda_oe_out |-> oe_gone) else $error("data held too long");
    oe_scl_low_a: assert property ($changed(sda_oe_out) |-> !scl_in) else $error("data moved");
    hold_rise_a: assert property ($rose(cpu_reset_out) |-> scl_in) else $error("bad hold");
    hold_fall_a: assert property ($fell(cpu_reset_out) |-> scl_in) else $error("bad free");
    stay_free_a: assert property ($fell(cpu_reset_out) |-> held_low) else $error("bounce");
    addr_step_a: assert property ($changed(ram_addr_out) |->
        ram_addr_out == $past(ram_addr_out) + 1'b1 || ram_addr_out == '0) else $error("skip");
    addr_held_a: assert property ($changed(ram_addr_out) && ram_addr_out != '0
        |-> cpu_reset_out) else $error("write while running");
    busy_held_a: assert property (ram_busy_out && $past(ram_busy_out, 2)
        |-> cpu_reset_out) else $error("stream while running");
endmodule
bind mrl_loader mrl_loader_checker #(.RAM_AW(RAM_AW)) i_chk (.clk_in(clk_in),
    .reset_in(reset_in), .scl_in(scl_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .cpu_reset_out(cpu_reset_out), .ram_addr_out(ram_addr_out), .ram_busy_out(ram_busy_out));

// [verif/mrl_loader_tb.sv]
/* Self-checking bench for mrl_loader: load, readback, release, foreign address.
   Assumes the host model owns the bus clock; data wire has a pull-up. */
`include "mrl_defs.vh"
module mrl_loader_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int N = 6;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic strap = 1'b1;
    logic scl, sda_drv, sda_oe, sda_o, cpu_rst, busy;
    logic [`MRL_RAM_AW-1:0] addr;
    wire sda = sda_drv & ~(sda_oe & ~sda_o);
    int mismatches = 0;
    int n_compared = 0;
    always #20 clk_in = ~clk_in;
    mrl_loader i_dut (.clk_in(clk_in), .reset_in(reset_in), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_o), .sda_oe_out(sda_oe), .address_select_strap_in(strap),
        .cpu_reset_out(cpu_rst), .ram_addr_out(addr), .ram_busy_out(busy));
    mrl_host_model i_host (.clk_in(clk_in), .sda_line_in(sda), .scl_out(scl),
        .sda_drv_out(sda_drv));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function automatic logic [7:0] pat(int i);
        return {i[3:0], ~i[3:0]};
    endfunction
    task automatic open_sub(input logic [7:0] sub);
        logic a;
        i_host.bus_start;
        i_host.put_byte({`MRL_ADDR_HI, strap, 1'b0}, a);
        check(a, 1'b1);
        i_host.put_byte(sub, a);
        check(a, 1'b1);
    endtask
    task automatic t_foreign;
        logic a;
        i_host.bus_start;
        i_host.put_byte({`MRL_ADDR_HI, ~strap, 1'b0}, a);
        check(a, 1'b0);
        i_host.bus_stop;
    endtask
    task automatic t_load;
        logic a;
        open_sub(`MRL_SUB_WRITE);
        check(cpu_rst, 1'b1);
        // More bytes than the FIFO holds, so draining must keep pace
        for (int i = 0; i < N; i++) begin
            i_host.put_byte(pat(i), a);
            check(a, 1'b1);
        end
        i_host.bus_stop;
        for (int k = 0; k < 200 && busy !== 1'b0; k++) @(posedge clk_in);
        check(busy, 1'b0);
        check(addr, N);
        check(cpu_rst, 1'b1);
    endtask
    task automatic t_readback;
        logic a;
        logic [7:0] d;
        open_sub(`MRL_SUB_READ);
        i_host.bus_stop;
        check(cpu_rst, 1'b1);
        i_host.bus_start;
        i_host.put_byte({`MRL_ADDR_HI, strap, 1'b1}, a);
        check(a, 1'b1);
        for (int i = 0; i < N; i++) begin
            i_host.get_byte(i < N - 1, d);
            check(d, pat(i));
        end
        i_host.bus_stop;
        check(cpu_rst, 1'b1);
    endtask
    task automatic t_release(input logic [7:0] v);
        logic a;
        open_sub(`MRL_SUB_RELEASE);
        i_host.put_byte(v, a);
        check(a, 1'b1);
        check(cpu_rst, 1'b0);
        i_host.bus_stop;
    endtask
    task automatic test_done;
        if (mismatches == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk_in);
        reset_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        check(cpu_rst, 1'b0);
        t_foreign;
        t_load;
        t_release(8'hFF);
        t_readback;
        t_release(8'h00);
        @(posedge clk_in);
        strap <= 1'b0;
        t_foreign;
        t_release(8'h3C);
        test_done;
    end
    initial begin
        repeat (40000) @(posedge clk_in);
        mismatches++;
        test_done;
    end
endmodule
